// ### hw/t8c_pkg.sv
// constants for the 8-bit timer/counter block
`default_nettype none
package t8c_pkg;
  localparam logic [7:0] ADDR_CTRL_B = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_CMP_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_B = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam int CTRL_FORCE_A = 7;
  localparam int CTRL_FORCE_B = 6;
  localparam int CTRL_WAVE2 = 3;
  localparam int BIT_MATCH_B = 2;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_OVF = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int DIV_8 = 8;
  localparam int DIV_64 = 64;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;
  localparam int PRESCALE_W = 10;
  typedef enum logic [2:0] {
    CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
    CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
  } t8c_clksel_e;
  typedef enum logic [1:0] {
    OM_OFF = 2'b00, OM_TOGGLE = 2'b01, OM_CLEAR = 2'b10, OM_SET = 2'b11
  } t8c_outmode_e;
endpackage : t8c_pkg
`default_nettype wire

// ### hw/t8c_tick_if.sv
// clock select request and timer tick between the timer and its clock source
`default_nettype none
interface t8c_tick_if;
  import t8c_pkg::*;
  t8c_clksel_e clockSel;
  logic tick;
  modport src (input clockSel, output tick);
  modport sink (output clockSel, input tick);
endinterface : t8c_tick_if
`default_nettype wire

// ### hw/t8c_clock_sel.sv
// prescaler and external count pin edge detection producing the timer tick
`default_nettype none
module t8c_clock_sel
  import t8c_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic extCountPin,
  t8c_tick_if.src tk
);
  logic [PRESCALE_W-1:0] prescale_q;
  logic extMeta_q, extSync_q, extLast_q;

  // free-running prescaler, shared by all divided rates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  // pin is read even when driven as an output, so software can clock it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      extMeta_q <= 1'b0;
      extSync_q <= 1'b0;
      extLast_q <= 1'b0;
    end else begin
      extMeta_q <= extCountPin;
      extSync_q <= extMeta_q;
      extLast_q <= extSync_q;
    end
  end

  function automatic logic divDone(input logic [PRESCALE_W-1:0] cnt, input int div);
    divDone = (cnt & PRESCALE_W'(div - 1)) == PRESCALE_W'(div - 1);
  endfunction : divDone

  always_comb begin
    unique case (tk.clockSel)
      CS_STOP: tk.tick = 1'b0;
      CS_DIV1: tk.tick = 1'b1;
      CS_DIV8: tk.tick = divDone(prescale_q, DIV_8);
      CS_DIV64: tk.tick = divDone(prescale_q, DIV_64);
      CS_DIV256: tk.tick = divDone(prescale_q, DIV_256);
      CS_DIV1024: tk.tick = divDone(prescale_q, DIV_1024);
      CS_EXT_FALL: tk.tick = extLast_q & ~extSync_q;
      CS_EXT_RISE: tk.tick = ~extLast_q & extSync_q;
    endcase
  end
endmodule : t8c_clock_sel
`default_nettype wire

// ### hw/t8c_timer.sv
// 8-bit timer/counter: control b, count, compares, mask, flags over AHB-Lite
// What this block does
// - force-match A strobe applies out mode A, only in non-PWM modes
// - force-match B strobe applies out mode B, only in non-PWM modes
// - forced matches set no flag and never clear the counter
// - force-match bits are strobes and always read zero
// - reserved bits of control b, mask and flags read zero
// - clock select: stop, io clock, io clock divided by 8/64/256/1024
// - codes 110 and 111 count falling or rising pin edges
// - count pin edges count even when pin drives as output
// - count register is directly readable and writable
// - writing the count blocks the compare match on the next tick
// - both compare values are compared with the count continuously
// - mask bits 2,1,0 gate flags with the global enable into requests
// - match B flag sets on match, clears on vector or write one
// - match A flag sets on match, clears on vector or write one
// - overflow flag sets at mode point, clears on vector or write one
// - non-PWM out modes: off, toggle, clear, set on match
// - wave mode picks normal, CTC, fast or phase PWM and top
//
// Implementation choices: the address map and the AHB-Lite slave port.
`default_nettype none
module t8c_timer
  import t8c_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [1:0] waveModeLow,
  input wire logic [1:0] outModeA,
  input wire logic [1:0] outModeB,
  input wire logic globalIrqEn,
  input wire logic vectorAckA,
  input wire logic vectorAckB,
  input wire logic vectorAckOvf,
  input wire logic extCountPin,
  output logic waveOutA,
  output logic waveOutB,
  output logic waveEnA,
  output logic waveEnB,
  output logic irqMatchA,
  output logic irqMatchB,
  output logic irqOverflow
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] dataAddr_q;
  logic dataWrite_q, dataActive_q;
  logic waveMode2_q;
  t8c_clksel_e clockSel_q;
  logic [7:0] count_q, cmpA_q, cmpB_q;
  logic [2:0] mask_q, flags_q;
  logic countDown_q, blockMatch_q;
  logic waveA_q, waveB_q;
  logic [2:0] mode;
  logic isPwm, isPhase, isFast, topIsA;
  logic [7:0] top;
  logic tick, wrCtrl, wrCount, wrCmpA, wrCmpB, wrMask, wrFlags;
  logic forceA, forceB, eqA, eqB, matchA, matchB, atBottom, ovfEvent;
  logic [7:0] wdata;

  t8c_tick_if tk ();

  t8c_clock_sel clockSource (
    .clock(clock),
    .rst(rst),
    .extCountPin(extCountPin),
    .tk(tk.src)
  );

  assign tk.clockSel = clockSel_q;
  assign tick = tk.tick;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataActive_q <= 1'b0;
      dataWrite_q <= 1'b0;
      dataAddr_q <= 8'h00;
    end else if (hready) begin
      dataActive_q <= hsel & htrans[1];
      dataWrite_q <= hwrite;
      dataAddr_q <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdata = hwdata[7:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  assign wrCtrl = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_CTRL_B);
  assign wrCount = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_COUNT);
  assign wrCmpA = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_CMP_A);
  assign wrCmpB = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_CMP_B);
  assign wrMask = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_MASK);
  assign wrFlags = dataActive_q & dataWrite_q & hit(dataAddr_q, ADDR_FLAGS);

  // read mux over register flops; unmapped addresses read zero
  always_comb begin
    hrdata = 32'h00000000;
    if (dataActive_q && !dataWrite_q) begin
      unique case (dataAddr_q)
        ADDR_CTRL_B: hrdata[7:0] = {4'h0, waveMode2_q, clockSel_q};
        ADDR_COUNT: hrdata[7:0] = count_q;
        ADDR_CMP_A: hrdata[7:0] = cmpA_q;
        ADDR_CMP_B: hrdata[7:0] = cmpB_q;
        ADDR_MASK: hrdata[7:0] = {5'h00, mask_q};
        ADDR_FLAGS: hrdata[7:0] = {5'h00, flags_q};
        default: hrdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waveMode2_q <= 1'b0;
      clockSel_q <= CS_STOP;
    end else if (wrCtrl) begin
      waveMode2_q <= wdata[CTRL_WAVE2];
      clockSel_q <= t8c_clksel_e'(wdata[2:0]);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmpA_q <= RESET_BYTE;
      cmpB_q <= RESET_BYTE;
    end else begin
      if (wrCmpA) begin
        cmpA_q <= wdata;
      end
      if (wrCmpB) begin
        cmpB_q <= wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= 3'b000;
    end else if (wrMask) begin
      mask_q <= wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: 1,5 phase correct; 3,7 fast; 2,5,7 take top from compare A
  assign mode = {waveMode2_q, waveModeLow};
  assign isPhase = (waveModeLow == 2'b01);
  assign isFast = (waveModeLow == 2'b11);
  assign isPwm = isPhase | isFast;
  assign topIsA = (mode == 3'd2) | (mode == 3'd5) | (mode == 3'd7);
  assign top = topIsA ? cmpA_q : COUNT_MAX;

  // strobes are never stored, so they read back as zero
  assign forceA = wrCtrl & wdata[CTRL_FORCE_A] & ~isPwm;
  assign forceB = wrCtrl & wdata[CTRL_FORCE_B] & ~isPwm;

  assign eqA = (count_q == cmpA_q);
  assign eqB = (count_q == cmpB_q);
  // a count write removes the match on the following tick
  assign matchA = tick & eqA & ~blockMatch_q;
  assign matchB = tick & eqB & ~blockMatch_q;
  assign atBottom = (count_q == COUNT_BOTTOM);

  always_comb begin
    if (isPhase) begin
      ovfEvent = tick & atBottom & countDown_q;
    end else if (mode == 3'd7) begin
      ovfEvent = tick & (count_q == top);
    end else begin
      ovfEvent = tick & (count_q == COUNT_MAX);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter; a software write takes priority over a tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= RESET_BYTE;
      countDown_q <= 1'b0;
    end else if (wrCount) begin
      count_q <= wdata;
    end else if (tick) begin
      if (isPhase) begin
        if (!countDown_q && count_q == top) begin
          countDown_q <= 1'b1;
          count_q <= count_q - 1'b1;
        end else if (countDown_q && atBottom) begin
          countDown_q <= 1'b0;
          count_q <= count_q + 1'b1;
        end else begin
          count_q <= countDown_q ? count_q - 1'b1 : count_q + 1'b1;
        end
      end else begin
        // only the counter's own top clears it, never a forced match
        count_q <= (count_q == top) ? COUNT_BOTTOM : count_q + 1'b1;
        countDown_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      blockMatch_q <= 1'b0;
    end else if (wrCount) begin
      blockMatch_q <= 1'b1;
    end else if (tick) begin
      blockMatch_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: set beats clear so no event is lost
  function automatic logic nextFlag(input logic cur, input logic setEv, input logic clrEv);
    nextFlag = setEv | (cur & ~clrEv);
  endfunction : nextFlag

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q <= 3'b000;
    end else begin
      flags_q[BIT_MATCH_B] <= nextFlag(flags_q[BIT_MATCH_B], matchB,
        vectorAckB | (wrFlags & wdata[BIT_MATCH_B]));
      flags_q[BIT_MATCH_A] <= nextFlag(flags_q[BIT_MATCH_A], matchA,
        vectorAckA | (wrFlags & wdata[BIT_MATCH_A]));
      flags_q[BIT_OVF] <= nextFlag(flags_q[BIT_OVF], ovfEvent,
        vectorAckOvf | (wrFlags & wdata[BIT_OVF]));
    end
  end

  assign irqMatchB = globalIrqEn & mask_q[BIT_MATCH_B] & flags_q[BIT_MATCH_B];
  assign irqMatchA = globalIrqEn & mask_q[BIT_MATCH_A] & flags_q[BIT_MATCH_A];
  assign irqOverflow = globalIrqEn & mask_q[BIT_OVF] & flags_q[BIT_OVF];

  ////////////////////////////////////////////////////////////////////////////
  // waveform outputs
  function automatic logic nonPwmOut(input logic cur, input logic [1:0] om);
    unique case (t8c_outmode_e'(om))
      OM_OFF: nonPwmOut = cur;
      OM_TOGGLE: nonPwmOut = ~cur;
      OM_CLEAR: nonPwmOut = 1'b0;
      OM_SET: nonPwmOut = 1'b1;
    endcase
  endfunction : nonPwmOut

  // pwm: toggle allowed only on channel A with wave mode bit 2 set
  function automatic logic pwmOut(input logic cur, input logic [1:0] om, input logic canToggle,
                                  input logic matchEv, input logic bottomEv, input logic down);
    pwmOut = cur;
    if (om == OM_TOGGLE) begin
      if (canToggle && matchEv) begin
        pwmOut = ~cur;
      end
    end else if (om[1]) begin
      if (matchEv) begin
        pwmOut = om[0] ^ down;
      end else if (bottomEv) begin
        pwmOut = ~om[0];
      end
    end
  endfunction : pwmOut

  logic bottomTick;
  assign bottomTick = tick & isFast & (count_q == top);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waveA_q <= 1'b0;
      waveB_q <= 1'b0;
    end else if (!isPwm) begin
      if (matchA || forceA) begin
        waveA_q <= nonPwmOut(waveA_q, outModeA);
      end
      if (matchB || forceB) begin
        waveB_q <= nonPwmOut(waveB_q, outModeB);
      end
    end else begin
      waveA_q <= pwmOut(waveA_q, outModeA, waveMode2_q, matchA, bottomTick, isPhase & countDown_q);
      waveB_q <= pwmOut(waveB_q, outModeB, 1'b0, matchB, bottomTick, isPhase & countDown_q);
    end
  end

  assign waveOutA = waveA_q;
  assign waveOutB = waveB_q;
  assign waveEnA = (outModeA != OM_OFF);
  assign waveEnB = (outModeB != OM_OFF);
endmodule : t8c_timer
`default_nettype wire

// ### testbench/t8c_timer_assertions.sv
// concurrent checks on the ports of the 8-bit timer block
`default_nettype none
module t8c_timer_checker
  import t8c_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] waveModeLow,
  input wire logic [1:0] outModeA,
  input wire logic [1:0] outModeB,
  input wire logic globalIrqEn,
  input wire logic waveOutA,
  input wire logic waveOutB,
  input wire logic waveEnA,
  input wire logic irqMatchA,
  input wire logic irqMatchB,
  input wire logic irqOverflow
);
  logic dataPh_q;
  logic dataWr_q;
  logic [7:0] dataAddr_q;
  // data phase tracking, so read data is judged against its own address phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataPh_q <= 1'b0;
      dataWr_q <= 1'b0;
      dataAddr_q <= 8'h00;
    end else begin
      dataPh_q <= hsel && hready && htrans[1];
      dataWr_q <= hwrite;
      dataAddr_q <= haddr;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence sRead(logic [7:0] a);
    dataPh_q && !dataWr_q && dataAddr_q == a;
  endsequence
  sequence sForce(int b);
    dataPh_q && dataWr_q && dataAddr_q == ADDR_CTRL_B && hwdata[b] && !waveModeLow[0];
  endsequence
  AST_FORCE_RD: assert property (sRead(ADDR_CTRL_B) |-> hrdata[7:6] == 2'b00)
    else $error("force bits read nonzero");
  AST_RSV_CTRL: assert property (sRead(ADDR_CTRL_B) |-> hrdata[5:4] == 2'b00)
    else $error("control reserved bits nonzero");
  AST_RSV_MASK: assert property (sRead(ADDR_MASK) |-> hrdata[7:3] == 5'h00)
    else $error("mask reserved bits nonzero");
  AST_RSV_FLG: assert property (sRead(ADDR_FLAGS) |-> hrdata[7:3] == 5'h00)
    else $error("flag reserved bits nonzero");
  AST_FORCE_A: assert property (sForce(CTRL_FORCE_A) ##0 outModeA == OM_CLEAR |=> !waveOutA)
    else $error("forced match a did not clear output");
  AST_FORCE_B: assert property (sForce(CTRL_FORCE_B) ##0 outModeB == OM_CLEAR |=> !waveOutB)
    else $error("forced match b did not clear output");
  AST_EN_A: assert property (waveEnA == (outModeA != OM_OFF))
    else $error("output a enable wrong");
  AST_IRQ_GATE: assert property (!globalIrqEn |-> !(irqMatchA || irqMatchB || irqOverflow))
    else $error("request without global enable");
  AST_IRQ_FLAG: assert property (sRead(ADDR_FLAGS) ##0 irqMatchA |-> hrdata[BIT_MATCH_A])
    else $error("request a without its flag");
endmodule : t8c_timer_checker
bind t8c_timer t8c_timer_checker u_chk (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .waveModeLow, .outModeA, .outModeB, .globalIrqEn, .waveOutA, .waveOutB, .waveEnA,
  .irqMatchA, .irqMatchB, .irqOverflow);
`default_nettype wire

// ### testbench/test_t8c_timer.sv
// self-checking bench for the 8-bit timer block
`default_nettype none
module test_t8c_timer
  import t8c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIVS[6] = '{0, 1, DIV_8, DIV_64, DIV_256, DIV_1024};
  logic clock, rst, hsel, hwrite, hreadyout, hresp, globalIrqEn, extCountPin;
  logic vectorAckA, vectorAckB, vectorAckOvf, waveOutA, waveOutB, waveEnA, waveEnB;
  logic irqMatchA, irqMatchB, irqOverflow;
  logic [7:0] haddr, v;
  logic [1:0] htrans, waveModeLow, outModeA, outModeB;
  logic [31:0] hwdata, hrdata;
  int failCount = 0;
  int checksDone = 0;
  int cycles = 0;
  t8c_timer dut (
    .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .waveModeLow, .outModeA, .outModeB, .globalIrqEn, .vectorAckA,
    .vectorAckB, .vectorAckOvf, .extCountPin, .waveOutA, .waveOutB, .waveEnA, .waveEnB,
    .irqMatchA, .irqMatchB, .irqOverflow
  );
  ////////////////////////////////////////
  task automatic testDone();
    $display("checks %0d errors %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : testDone
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rng(input string n, input logic [7:0] g, input int lo, input int hi);
    checksDone++;
    if ($isunknown(g) || g < lo || g > hi) begin
      failCount++;
      $display("Error %s exp %0d..%0d got %h", n, lo, hi, g);
    end
  endtask : rng
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  // hreadyout is always high here, but the master still waits on it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    // read data is taken at the edge that ends the data phase, before the design's flops move
    do begin
      @(posedge clock);
      r = hrdata[7:0];
    end while (hreadyout !== 1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    chk($sformatf("reg %h", a), e, r);
  endtask : rc
  ////////////////////////////////////////
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failCount++;
      $display("Error run exp done got timeout");
      testDone();
    end
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {rst, hsel, hwrite, globalIrqEn, extCountPin, vectorAckA, vectorAckB, vectorAckOvf} = 8'h80;
    {haddr, htrans, waveModeLow, outModeA, outModeB, hwdata} = '0;
    idle(2);
    rst <= 1'b0;
    idle(1);
    for (int a = 0; a <= 8'h18; a += 4) rc(8'(a), 8'h00);
    waveModeLow <= 2'b01;
    wr(ADDR_CTRL_B, 8'h38);
    rc(ADDR_CTRL_B, 8'h08);
    waveModeLow <= 2'b00;
    wr(ADDR_CTRL_B, 8'hC0);
    rc(ADDR_CTRL_B, 8'h00);
    wr(ADDR_MASK, 8'hFF);
    rc(ADDR_MASK, 8'h07);
    wr(ADDR_FLAGS, 8'hFF);
    rc(ADDR_FLAGS, 8'h00);
    wr(8'h18, 8'hFF);
    rc(8'h18, 8'h00);
    wr(ADDR_COUNT, 8'h5A);
    rc(ADDR_COUNT, 8'h5A);
    // compare matches while running from the io clock
    wr(ADDR_CMP_A, 8'h22);
    wr(ADDR_CMP_B, 8'h24);
    rc(ADDR_CMP_A, 8'h22);
    rc(ADDR_CMP_B, 8'h24);
    outModeA <= OM_TOGGLE;
    outModeB <= OM_SET;
    globalIrqEn <= 1'b1;
    wr(ADDR_COUNT, 8'h20);
    wr(ADDR_CTRL_B, 8'h01);
    idle(10);
    wr(ADDR_CTRL_B, 8'h00);
    rc(ADDR_FLAGS, 8'h06);
    chk("waves", 8'h03, {6'h0, waveOutB, waveOutA});
    chk("wave enables", 8'h03, {6'h0, waveEnB, waveEnA});
    chk("hresp", 8'h00, {7'h0, hresp});
    chk("irqs", 8'h06, {5'h0, irqMatchB, irqMatchA, irqOverflow});
    globalIrqEn <= 1'b0;
    idle(1);
    chk("irqs", 8'h00, {5'h0, irqMatchB, irqMatchA, irqOverflow});
    wr(ADDR_FLAGS, 8'h02);
    rc(ADDR_FLAGS, 8'h04);
    vectorAckB <= 1'b1;
    idle(1);
    vectorAckB <= 1'b0;
    rc(ADDR_FLAGS, 8'h00);
    // forced matches while stopped
    xfer(1'b0, ADDR_COUNT, 8'h00, v);
    outModeA <= OM_CLEAR;
    outModeB <= OM_CLEAR;
    wr(ADDR_CTRL_B, 8'h80);
    idle(1);
    chk("waveA", 8'h00, {7'h0, waveOutA});
    chk("waveB", 8'h01, {7'h0, waveOutB});
    wr(ADDR_CTRL_B, 8'h40);
    idle(1);
    chk("waveB", 8'h00, {7'h0, waveOutB});
    rc(ADDR_FLAGS, 8'h00);
    rc(ADDR_COUNT, v);
    wr(ADDR_COUNT, 8'hFD);
    wr(ADDR_CTRL_B, 8'h01);
    idle(6);
    wr(ADDR_CTRL_B, 8'h00);
    rc(ADDR_FLAGS, 8'h01);
    vectorAckOvf <= 1'b1;
    idle(1);
    vectorAckOvf <= 1'b0;
    rc(ADDR_FLAGS, 8'h00);
    // writing the count onto compare a must not raise its flag
    wr(ADDR_CMP_A, 8'h30);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    wr(ADDR_COUNT, 8'h30);
    idle(4);
    wr(ADDR_CTRL_B, 8'h00);
    rc(ADDR_FLAGS, 8'h00);
    waveModeLow <= 2'b10;
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h01);
    idle(40);
    wr(ADDR_CTRL_B, 8'h00);
    xfer(1'b0, ADDR_COUNT, 8'h00, v);
    rng("ctc count", v, 0, 5);
    waveModeLow <= 2'b00;
    for (int s = 6; s < 8; s++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, 8'(s));
      repeat (3) begin
        extCountPin <= 1'b1;
        idle(5);
        extCountPin <= 1'b0;
        idle(5);
      end
      wr(ADDR_CTRL_B, 8'h00);
      rc(ADDR_COUNT, 8'h03);
    end
    // window of four divided periods; bus overhead adds a few io clocks
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL_B, 8'(i));
      idle(i == 0 ? 40 : 4 * DIVS[i]);
      wr(ADDR_CTRL_B, 8'h00);
      xfer(1'b0, ADDR_COUNT, 8'h00, v);
      rng("div count", v, i == 0 ? 0 : 4, i == 0 ? 0 : (i == 1 ? 10 : 5));
    end
    testDone();
  end
endmodule : test_t8c_timer
`default_nettype wire
